// file: nv_seq_map.vh
`ifndef NV_SEQ_MAP_VH
`define NV_SEQ_MAP_VH
// clock rate and derived timing
`define CORE_CLK_MHZ 125
`define SOFT_SEQUENCE_TIME_US 500
`define SOFT_SEQUENCE_CYCLES ((`SOFT_SEQUENCE_TIME_US * `CORE_CLK_MHZ))
`define RESTORE_DURATION_US 600
`define RESTORE_CYCLES ((`RESTORE_DURATION_US * `CORE_CLK_MHZ))
`define STORE_DURATION_US 8000
`define STORE_CYCLES ((`STORE_DURATION_US * `CORE_CLK_MHZ))
`define HW_SAVE_PULSE_MIN_NS 15
`define DELAY_TIME_NS 25
`define CORE_CLK_NS 8
`define WRITE_GRACE_CYCLES ((`DELAY_TIME_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define SOFT_CMD_DELAY_CYCLES 16
`define CNT_W 20
// sequencer states
`define ST_IDLE 3'h0
`define ST_GRACE 3'h1
`define ST_WAIT 3'h2
`define ST_STORE 3'h3
`define ST_RESTORE 3'h4
`endif

// file: sync_two_ff.v
`timescale 1ns/1ns
// two flip-flop level synchroniser
module sync_two_ff (
  input wire core_clk,
  input wire reset,
  input wire resetValue,
  input wire asyncIn,
  output reg syncOut
);
  reg firstStage;

  // first stage feeds only the second
  always @(posedge core_clk) begin
    if (reset) begin
      firstStage <= resetValue;
      syncOut <= resetValue;
    end else begin
      firstStage <= asyncIn;
      syncOut <= firstStage;
    end
  end
endmodule // sync_two_ff

// file: nv_store_recall_sequencer.v
`timescale 1ns/1ns
`include "nv_seq_map.vh"
// Behaviour
// - host reads and writes are dropped while a save or restore runs or the supply is below the trip level.
// - pin or power-fail saves are skipped when the array was not written since the last nonvolatile cycle.
// - a soft save or restore command that arrives while idle, outside the cycle the save pin falls, is acted on within 500 us while the supply stays high.
// - serial I/O stays locked after a save or restore command until the operation ends.
// - the working array is disabled for as long as the save pin is driven low from outside.
// - with no write latched and no save, the pin driver stays off and only the pull-up raises the pin.

// overview of the sequencer
// idle: host reads and writes are granted one cycle after the request
// a falling save pin or a low supply starts a save, but only if
// the working array was written since the last nonvolatile cycle
// a pin or supply save first opens a short grace window so a write in flight lands
// soft save and restore commands pass a fixed wait, then run
// serial I/O stays locked while a save or restore runs, except in the first cycle of a pin or supply save
// the save pin driver is enabled only while a save runs
// with the pin released, only the pull-up raises the pin
// the array is switched off while the pin is held low from outside
// the write latch is set by granted writes and cleared at the end
// of any nonvolatile cycle, a set in the same cycle winning
// a supply drop during the soft command wait drops the command
// serial clock spacing is the host's duty; the clock is only sampled
// every output is a flip-flop; the save pin, supply and serial clock levels pass two flip-flops
// all counts come from the map header, none is written inline
module nv_store_recall_sequencer (
  input wire core_clk,
  input wire reset,
  input wire supplyLow,
  input wire serialClk,
  input wire hwSaveBusyIn,
  input wire hostReadReq,
  input wire hostWriteReq,
  input wire softStoreCmd,
  input wire softRestoreCmd,
  output reg hwSaveBusyOut,
  output reg hwSaveBusyOe_n,
  output reg arrayEnable,
  output reg arrayRead,
  output reg arrayWrite,
  output reg ioLocked,
  output reg storeActive,
  output reg restoreActive,
  output reg writeLatched
);
  wire pinSync;
  wire supplyLowSync;
  wire sclkSync;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [`CNT_W-1:0] count;
  reg pendStore;
  reg pendRestore;
  reg sclkPrev;
  reg pinPrev;
  // supply low, save or restore running: host access refused
  wire busy;
  // synchronised save pin just went low
  wire pinFall;
  // array usable: the save pin is not held low
  wire arrayOn;
  // serial I/O locked in the coming cycle
  wire ioLockNext;
  // a host write is granted in the coming cycle
  wire arrayWriteNext;

  // save pin, supply and serial clock inputs pass two flip-flops
  sync_two_ff pinSyncInst (.core_clk(core_clk), .reset(reset), .resetValue(1'b1), .asyncIn(hwSaveBusyIn),
    .syncOut(pinSync));
  sync_two_ff supplySyncInst (.core_clk(core_clk), .reset(reset), .resetValue(1'b0), .asyncIn(supplyLow),
    .syncOut(supplyLowSync));
  sync_two_ff sclkSyncInst (.core_clk(core_clk), .reset(reset), .resetValue(1'b0), .asyncIn(serialClk),
    .syncOut(sclkSync));

  // host spacing is the host's concern; serial clock edges only observed
  always @(posedge core_clk) begin
    if (reset) begin
      sclkPrev <= 1'b0;
      pinPrev <= 1'b1;
    end else begin
      sclkPrev <= sclkSync;
      pinPrev <= pinSync;
    end
  end

  assign busy = (state == `ST_STORE) || (state == `ST_RESTORE) || supplyLowSync;
  assign pinFall = pinPrev && !pinSync;

  // next state
  always @* begin
    next_state = state;
    case (state)
      // idle: wait for a save trigger or a soft command
      `ST_IDLE: begin
        if (supplyLowSync || pinFall) begin
          if (writeLatched)
            next_state = `ST_GRACE;
        end else if (softStoreCmd || softRestoreCmd) begin
          next_state = `ST_WAIT;
        end
      end
      // grace: let a write in flight finish before the save
      `ST_GRACE: begin
        if (count == `WRITE_GRACE_CYCLES - 1)
          next_state = `ST_STORE;
      end
      // wait: soft command pending, acted on well inside its limit
      `ST_WAIT: begin
        if (supplyLowSync)
          next_state = `ST_IDLE;
        else if (count == `SOFT_CMD_DELAY_CYCLES - 1) begin
          if (pendStore)
            next_state = `ST_STORE;
          else if (pendRestore)
            next_state = `ST_RESTORE;
          else
            next_state = `ST_IDLE;
        end
      end
      // store: copy to the nonvolatile cells
      `ST_STORE: begin
        if (count == `STORE_CYCLES - 1)
          next_state = `ST_IDLE;
      end
      // restore: copy back into the working array
      `ST_RESTORE: begin
        if (count == `RESTORE_CYCLES - 1)
          next_state = `ST_IDLE;
      end
      default: next_state = `ST_IDLE;
    endcase
  end

  // state, counter and pending command
  always @(posedge core_clk) begin
    if (reset) begin
      state <= `ST_IDLE;
      count <= {`CNT_W{1'b0}};
      pendStore <= 1'b0;
      pendRestore <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state)
        count <= {`CNT_W{1'b0}};
      else
        count <= count + 1'b1;
      if (state == `ST_IDLE && next_state == `ST_WAIT) begin
        pendStore <= softStoreCmd;
        pendRestore <= !softStoreCmd && softRestoreCmd;
      end else if (next_state == `ST_IDLE) begin
        pendStore <= 1'b0;
        pendRestore <= 1'b0;
      end
    end
  end

  // write latch: set by writes, cleared when a save or restore completes; set wins
  always @(posedge core_clk) begin
    if (reset)
      writeLatched <= 1'b0;
    else if (arrayWriteNext)
      writeLatched <= 1'b1;
    else if (state == `ST_STORE && next_state == `ST_IDLE)
      writeLatched <= 1'b0;
    else if (state == `ST_RESTORE && next_state == `ST_IDLE)
      writeLatched <= 1'b0;
  end

  // array access gating; the grace state itself does not close writes, a low pin or supply does
  assign arrayOn = pinSync;
  assign ioLockNext = (state == `ST_WAIT) || (state == `ST_STORE) || (state == `ST_RESTORE);
  assign arrayWriteNext = hostWriteReq && arrayOn && !busy && !ioLockNext;

  // output notes
  // the pin output value is low outside reset; the enable decides driving
  // grants follow the request by one cycle and last as long as the request
  // store and restore flags mirror the running operation

  // registered outputs
  always @(posedge core_clk) begin
    if (reset) begin
      hwSaveBusyOut <= 1'b1;
      hwSaveBusyOe_n <= 1'b1;
      arrayEnable <= 1'b0;
      arrayRead <= 1'b0;
      arrayWrite <= 1'b0;
      ioLocked <= 1'b0;
      storeActive <= 1'b0;
      restoreActive <= 1'b0;
    end else begin
      hwSaveBusyOut <= 1'b0;
      hwSaveBusyOe_n <= !(next_state == `ST_STORE);
      arrayEnable <= arrayOn && !busy;
      arrayRead <= hostReadReq && arrayOn && !busy && !ioLockNext;
      arrayWrite <= arrayWriteNext;
      ioLocked <= ioLockNext;
      storeActive <= (next_state == `ST_STORE);
      restoreActive <= (next_state == `ST_RESTORE);
    end
  end
endmodule // nv_store_recall_sequencer

// file: nv_seq_asserts.sv
`timescale 1ns/1ns
module nv_seq_asserts (input wire core_clk, input wire reset, input wire hwSaveBusyIn,
  input wire softRestoreCmd, input wire supplyLow, input wire hwSaveBusyOe_n, input wire arrayEnable,
  input wire arrayRead, input wire arrayWrite, input wire ioLocked, input wire storeActive,
  input wire restoreActive, input wire writeLatched);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rf; (storeActive || restoreActive) [*2] |=> !(arrayRead || arrayWrite); endproperty
  a_rf: assert property (p_rf) else $error("grant while busy");
  property p_sk; !writeLatched && !ioLocked |=> !storeActive; endproperty
  a_sk: assert property (p_sk) else $error("needless save");
  property p_ss; softRestoreCmd && !ioLocked && !supplyLow |-> ##[1:40] restoreActive; endproperty
  a_ss: assert property (p_ss) else $error("slow command");
  property p_lk; (storeActive || restoreActive) |-> ioLocked; endproperty
  a_lk: assert property (p_lk) else $error("io not locked");
  property p_pn; !hwSaveBusyIn [*4] |-> !arrayEnable; endproperty
  a_pn: assert property (p_pn) else $error("array on");
  property p_oe; !writeLatched && !storeActive |-> hwSaveBusyOe_n; endproperty
  a_oe: assert property (p_oe) else $error("pin driven");
  c_rs: cover property (restoreActive);
  c_st: cover property (storeActive);
  c_wr: cover property (arrayWrite);
endmodule // nv_seq_asserts

// file: host_spi_model.sv
`timescale 1ns/1ns
// host side: clocks one frame, then posts one request
module host_spi_model (input wire core_clk, input wire go, input wire wr,
  output reg serialClk, output reg hostReadReq, output reg hostWriteReq);
  initial {serialClk, hostReadReq, hostWriteReq} = 3'h0;
  // 12.5 MHz frame clock, still and low between frames
  always @(posedge go) begin
    repeat (16) #40 serialClk = ~serialClk;
    @(negedge core_clk) {hostReadReq, hostWriteReq} <= {~wr, wr};
    @(negedge core_clk) {hostReadReq, hostWriteReq} <= 2'h0;
  end
endmodule // host_spi_model

// file: test_nv_store_recall_sequencer.sv
`timescale 1ns/1ns
module test_nv_store_recall_sequencer;
  reg core_clk = 0, reset = 1, supplyLow = 0, hwSaveBusyIn = 1, softStoreCmd = 0, softRestoreCmd = 0, go = 0, wr = 0;
  wire serialClk, hostReadReq, hostWriteReq, hwSaveBusyOut, hwSaveBusyOe_n, arrayEnable, arrayRead, arrayWrite;
  wire ioLocked, storeActive, restoreActive, writeLatched;
  integer miscompares = 0, n_checks = 0, grants = 0, i;
  nv_store_recall_sequencer u_dut (.*);
  host_spi_model u_host (.*);
  always #4 core_clk = ~core_clk;
  // count granted array accesses
  always @(posedge core_clk) if (!reset) grants <= grants + arrayRead + arrayWrite;
  task chk(input [31:0] s, input [31:0] e); begin
    n_checks = n_checks + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  end endtask
  task conclude; begin
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask
  task cyc(input integer n); repeat (n) @(negedge core_clk); endtask
  // one host frame, then compare granted count
  task acc(input w, input integer e); integer g; begin
    g = grants; wr = w; go = 1; cyc(100); go = 0; chk(grants - g, e);
  end endtask
  task tmo(input integer n, input integer m); begin chk(n < m, 1); if (n >= m) conclude; end endtask
  // pin low and supply low with nothing written: refused, no save
  task test_pin_supply; begin
    hwSaveBusyIn = 0; cyc(6);
    chk(arrayEnable, 0);
    chk(hwSaveBusyOe_n, 1);
    chk(storeActive, 0);
    acc(0, 0);
    hwSaveBusyIn = 1; cyc(4);
    supplyLow = 1; cyc(4); acc(1, 0);
    chk(storeActive, 0);
    chk(hwSaveBusyOe_n, 1);
    supplyLow = 0; cyc(4);
    acc(1, 1);
    chk(writeLatched, 1);
    $display("test pin and supply done");
  end endtask
  // soft restore locks I/O and clears the write latch
  task test_restore; begin
    softRestoreCmd = 1; cyc(1); softRestoreCmd = 0; cyc(2);
    chk(ioLocked, 1);
    for (i = 0; restoreActive !== 1'b1 && i < 40; i = i + 1) cyc(1);
    tmo(i, 40);
    acc(0, 0);
    for (i = 0; ioLocked !== 1'b0 && i < 80000; i = i + 1) cyc(1);
    tmo(i, 80000);
    chk(writeLatched, 0);
    $display("test restore done");
  end endtask
  // written array, short pin pulse: save runs and drives the pin
  task test_pin_save; begin
    acc(1, 1); hwSaveBusyIn = 0; cyc(2); hwSaveBusyIn = 1;
    for (i = 0; storeActive !== 1'b1 && i < 20; i = i + 1) cyc(1);
    tmo(i, 20);
    chk(hwSaveBusyOe_n, 0);
    $display("test pin save done");
  end endtask
  initial begin
    cyc(2); reset = 0; cyc(3);
    test_pin_supply;
    test_restore;
    test_pin_save;
    conclude;
  end
endmodule // test_nv_store_recall_sequencer
bind nv_store_recall_sequencer nv_seq_asserts u_chk (.*);
